// *** rtl/tcs_transfer_controller.v ***
// count, address, enable and status registers of the two-channel transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.vh"

module tcs_transfer_controller #(
   parameter COUNT_W = 16,
   parameter MADDR_W = 20,
   parameter IOADDR_W = 16
) (
   input  wire                clk,          // system clock
   input  wire                sys_rst,      // async reset, active high
   input  wire [7:0]          io_addr,      // cpu io address, low byte
   input  wire [7:0]          io_wdata,     // cpu write data
   input  wire                io_wr,        // one-cycle write strobe
   input  wire                io_rd,        // read select
   output reg  [7:0]          io_rdata,     // read data, registered
   output wire                io_hit,       // address belongs to this block
   input  wire                nmi_pulse,    // non-maskable interrupt event
   input  wire [1:0]          chan_req,     // per-channel request from engine
   output wire [1:0]          chan_grant,   // one-hot grant, channel 0 first
   input  wire                byte_done,    // one byte moved on granted channel
   input  wire                ch1_mem_step, // channel 1 memory address steps
   input  wire                ch1_mem_down, // 1 decrement, 0 increment
   output wire [1:0]          chan_active,  // channel may transfer
   output wire [COUNT_W-1:0]  ch0_count,    // channel 0 bytes left
   output wire [COUNT_W-1:0]  ch1_count,    // channel 1 bytes left
   output wire [MADDR_W-1:0]  ch1_mem_addr, // channel 1 memory address
   output wire [IOADDR_W-1:0] ch1_io_addr,  // channel 1 io address
   output wire                irq           // termination interrupt request
);

   reg [COUNT_W-1:0]  ch0_count_reg;
   reg [COUNT_W-1:0]  ch1_count_reg;
   reg [MADDR_W-1:0]  ch1_maddr_reg;
   reg [IOADDR_W-1:0] ch1_ioaddr_reg;
   wire [1:0]         chan_en;
   reg [1:0]          irq_en_reg;
   reg                master_en_reg;
   reg [7:0]          rdata_next;

   wire       st_wr = io_wr && (io_addr == `TCS_STATUS);
   wire [1:0] wr_permit;
   wire [1:0] count_end;
   wire [7:0] status_val;
   wire [1:0] end_irq;
   reg        hit_next;

   // nmi comes from a pin; three stages keep metastability out of the enables
   reg        nmi_s1_reg;
   reg        nmi_s2_reg;
   reg        nmi_s3_reg;
   reg        nmi_level_reg;
   reg        nmi_level_next;
   wire       nmi_edge;

   // one write strobe per register byte
   wire       wr_ch0_bc_lo  = io_wr && (io_addr == `TCS_CH0_BC_LO);
   wire       wr_ch0_bc_hi  = io_wr && (io_addr == `TCS_CH0_BC_HI);
   wire       wr_ch1_ma_lo  = io_wr && (io_addr == `TCS_CH1_MA_LO);
   wire       wr_ch1_ma_mid = io_wr && (io_addr == `TCS_CH1_MA_MID);
   wire       wr_ch1_ma_hi  = io_wr && (io_addr == `TCS_CH1_MA_HI);
   wire       wr_ch1_io_lo  = io_wr && (io_addr == `TCS_CH1_IO_LO);
   wire       wr_ch1_io_hi  = io_wr && (io_addr == `TCS_CH1_IO_HI);
   wire       wr_ch1_bc_lo  = io_wr && (io_addr == `TCS_CH1_BC_LO);
   wire       wr_ch1_bc_hi  = io_wr && (io_addr == `TCS_CH1_BC_HI);

   // byte moves per channel and the unit step of each counter
   wire               ch0_move  = byte_done && chan_grant[0];
   wire               ch1_move  = byte_done && chan_grant[1];
   wire [COUNT_W-1:0] count_one = {{(COUNT_W-1){1'b0}}, 1'b1};
   wire [MADDR_W-1:0] maddr_one = {{(MADDR_W-1){1'b0}}, 1'b1};

   assign chan_active = chan_en & {2{master_en_reg}};
   wire [1:0] req_ok = chan_req & chan_active;
   assign chan_grant = req_ok[0] ? 2'b01 : {req_ok[1], 1'b0};
   assign end_irq = ~chan_en & irq_en_reg;
   assign irq = |end_irq;

   assign wr_permit[0] = st_wr && !io_wdata[`TCS_BIT_CH0_GUARD];
   assign wr_permit[1] = st_wr && !io_wdata[`TCS_BIT_CH1_GUARD];
   assign count_end[0] = byte_done && chan_grant[0] && (ch0_count_reg == {{(COUNT_W-1){1'b0}}, 1'b1});
   assign count_end[1] = byte_done && chan_grant[1] && (ch1_count_reg == {{(COUNT_W-1){1'b0}}, 1'b1});

   // guards store nothing and always read 1, bit 1 reads 0
   assign status_val[`TCS_BIT_CH1_EN]     = chan_en[1];
   assign status_val[`TCS_BIT_CH0_EN]     = chan_en[0];
   assign status_val[`TCS_BIT_CH1_GUARD]  = 1'b1;
   assign status_val[`TCS_BIT_CH0_GUARD]  = 1'b1;
   assign status_val[`TCS_BIT_CH1_IRQ_EN] = irq_en_reg[1];
   assign status_val[`TCS_BIT_CH0_IRQ_EN] = irq_en_reg[0];
   assign status_val[1]                   = 1'b0;
   assign status_val[`TCS_BIT_MASTER_EN]  = master_en_reg;

   // the hole between io address and ch1 count bytes is not decoded
   always @* begin
      hit_next = 1'b0;
      case (io_addr)
         `TCS_CH0_BC_LO,
         `TCS_CH0_BC_HI,
         `TCS_CH1_MA_LO,
         `TCS_CH1_MA_MID,
         `TCS_CH1_MA_HI,
         `TCS_CH1_IO_LO,
         `TCS_CH1_IO_HI,
         `TCS_CH1_BC_LO,
         `TCS_CH1_BC_HI,
         `TCS_STATUS:     hit_next = 1'b1;
         default:         hit_next = 1'b0;
      endcase
   end

   assign io_hit = hit_next;

   assign ch0_count    = ch0_count_reg;
   assign ch1_count    = ch1_count_reg;
   assign ch1_mem_addr = ch1_maddr_reg;
   assign ch1_io_addr  = ch1_ioaddr_reg;

   // enable bits, per channel
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_chan
         reg en_bit_reg;

         always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               en_bit_reg <= 1'b0;
            end else if (count_end[g]) begin
               // hardware termination wins over a same-cycle write
               en_bit_reg <= 1'b0;
            end else if (wr_permit[g]) begin
               en_bit_reg <= io_wdata[`TCS_BIT_CH0_EN + g];
            end
         end

         assign chan_en[g] = en_bit_reg;
      end
   endgenerate

   // first stage feeds only the second; the pin must stay high two clocks
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         nmi_s1_reg    <= 1'b0;
         nmi_s2_reg    <= 1'b0;
         nmi_s3_reg    <= 1'b0;
         nmi_level_reg <= 1'b0;
      end else begin
         nmi_s1_reg    <= nmi_pulse;
         nmi_s2_reg    <= nmi_s1_reg;
         nmi_s3_reg    <= nmi_s2_reg;
         nmi_level_reg <= nmi_level_next;
      end
   end

   // a level counts once the second and third stages agree
   always @* begin
      nmi_level_next = nmi_level_reg;
      if (nmi_s2_reg == nmi_s3_reg) begin
         nmi_level_next = nmi_s3_reg;
      end
   end

   // level resets low like the idle pin, so no false event follows reset
   assign nmi_edge = nmi_level_next && !nmi_level_reg;

   // irq enables follow any status write, guards do not apply to them
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_en_reg <= 2'b00;
      end else if (st_wr) begin
         irq_en_reg <= {io_wdata[`TCS_BIT_CH1_IRQ_EN], io_wdata[`TCS_BIT_CH0_IRQ_EN]};
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         master_en_reg <= 1'b0;
      end else if ((wr_permit[0] && io_wdata[`TCS_BIT_CH0_EN]) ||
                   (wr_permit[1] && io_wdata[`TCS_BIT_CH1_EN])) begin
         // a set in the nmi cycle wins, so a restart is not lost
         master_en_reg <= 1'b1;
      end else if (nmi_edge) begin
         master_en_reg <= 1'b0;
      end
   end

   // byte-wide access, low byte at lowest address; byte move beats cpu write
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ch0_count_reg <= {COUNT_W{1'b0}};
      end else if (ch0_move) begin
         ch0_count_reg <= ch0_count_reg - count_one;
      end else if (wr_ch0_bc_lo) begin
         ch0_count_reg[7:0] <= io_wdata;
      end else if (wr_ch0_bc_hi) begin
         ch0_count_reg[COUNT_W-1:8] <= io_wdata[COUNT_W-9:0];
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ch1_count_reg <= {COUNT_W{1'b0}};
      end else if (ch1_move) begin
         ch1_count_reg <= ch1_count_reg - count_one;
      end else if (wr_ch1_bc_lo) begin
         ch1_count_reg[7:0] <= io_wdata;
      end else if (wr_ch1_bc_hi) begin
         ch1_count_reg[COUNT_W-1:8] <= io_wdata[COUNT_W-9:0];
      end
   end

   // a cpu write landing in a ch1 move cycle is dropped, the move has priority
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ch1_maddr_reg <= {MADDR_W{1'b0}};
      end else if (ch1_move) begin
         if (ch1_mem_step) begin
            ch1_maddr_reg <= ch1_mem_down ? ch1_maddr_reg - maddr_one
                                          : ch1_maddr_reg + maddr_one;
         end
      end else if (wr_ch1_ma_lo) begin
         ch1_maddr_reg[7:0] <= io_wdata;
      end else if (wr_ch1_ma_mid) begin
         ch1_maddr_reg[15:8] <= io_wdata;
      end else if (wr_ch1_ma_hi) begin
         ch1_maddr_reg[MADDR_W-1:16] <= io_wdata[MADDR_W-17:0];
      end
   end

   // the io address never steps; it only follows cpu writes
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ch1_ioaddr_reg <= {IOADDR_W{1'b0}};
      end else if (!ch1_move && wr_ch1_io_lo) begin
         ch1_ioaddr_reg[7:0] <= io_wdata;
      end else if (!ch1_move && wr_ch1_io_hi) begin
         ch1_ioaddr_reg[IOADDR_W-1:8] <= io_wdata[IOADDR_W-9:0];
      end
   end

   // read mux; upper address bits above the field read as zero
   always @* begin
      rdata_next = 8'h00;
      case (io_addr)
         `TCS_CH0_BC_LO:  rdata_next = ch0_count_reg[7:0];
         `TCS_CH0_BC_HI:  rdata_next = ch0_count_reg[15:8];
         `TCS_CH1_MA_LO:  rdata_next = ch1_maddr_reg[7:0];
         `TCS_CH1_MA_MID: rdata_next = ch1_maddr_reg[15:8];
         `TCS_CH1_MA_HI:  rdata_next = {4'h0, ch1_maddr_reg[19:16]};
         `TCS_CH1_IO_LO:  rdata_next = ch1_ioaddr_reg[7:0];
         `TCS_CH1_IO_HI:  rdata_next = ch1_ioaddr_reg[15:8];
         `TCS_CH1_BC_LO:  rdata_next = ch1_count_reg[7:0];
         `TCS_CH1_BC_HI:  rdata_next = ch1_count_reg[15:8];
         `TCS_STATUS:     rdata_next = status_val;
         default:         rdata_next = 8'h00;
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         io_rdata <= rdata_next;
      end
   end

endmodule
`default_nettype wire

// *** shared/tcs_regs.vh ***
// register offsets, field positions and the status reset value of the transfer controller
`ifndef TCS_REGS_VH
`define TCS_REGS_VH
`define TCS_CH0_BC_LO      8'h26
`define TCS_CH0_BC_HI      8'h27
`define TCS_CH1_MA_LO      8'h28
`define TCS_CH1_MA_MID     8'h29
`define TCS_CH1_MA_HI      8'h2A
`define TCS_CH1_IO_LO      8'h2B
`define TCS_CH1_IO_HI      8'h2C
`define TCS_CH1_BC_LO      8'h2E
`define TCS_CH1_BC_HI      8'h2F
`define TCS_STATUS         8'h30
`define TCS_BIT_CH1_EN     7
`define TCS_BIT_CH0_EN     6
`define TCS_BIT_CH1_GUARD  5
`define TCS_BIT_CH0_GUARD  4
`define TCS_BIT_CH1_IRQ_EN 3
`define TCS_BIT_CH0_IRQ_EN 2
`define TCS_BIT_MASTER_EN  0
`define TCS_STATUS_RESET   8'h30
`endif

// *** tb/tcs_partner.sv ***
// transfer-side partner: requests service and acknowledges granted bytes
`timescale 1ns/1ps
`default_nettype none
module tcs_partner (
   input  wire logic       clk,        // system clock
   input  wire logic [1:0] want,       // channels with data pending
   input  wire logic [3:0] lag,        // cycles before a byte completes
   input  wire logic [1:0] chan_grant, // grant from controller
   output var  logic [1:0] chan_req,   // service request
   output var  logic       byte_done   // one byte moved
);
   logic [3:0] wait_cnt;
   assign chan_req = want;
   initial begin
      byte_done = 1'b0;
      wait_cnt = 4'h0;
   end
   // never two strobes in a row, so an ending grant is seen first
   always @(posedge clk) begin
      byte_done <= 1'b0;
      if (chan_grant == 2'b00) wait_cnt <= 4'h0;
      else if (wait_cnt >= lag && !byte_done) begin
         byte_done <= 1'b1;
         wait_cnt <= 4'h0;
      end else wait_cnt <= wait_cnt + 4'h1;
   end
endmodule
`default_nettype wire

// *** tb/tcs_transfer_controller_asserts.sv ***
// concurrent checks on the transfer controller ports
`timescale 1ns/1ps
`default_nettype none
module tcs_transfer_controller_asserts #(parameter COUNT_W = 16) (
   input wire logic               clk,
   input wire logic               sys_rst,
   input wire logic [7:0]         io_addr,
   input wire logic [7:0]         io_wdata,
   input wire logic               io_wr,
   input wire logic               io_rd,
   input wire logic [7:0]         io_rdata,
   input wire logic               io_hit,
   input wire logic               nmi_pulse,
   input wire logic [1:0]         chan_req,
   input wire logic [1:0]         chan_grant,
   input wire logic               byte_done,
   input wire logic [1:0]         chan_active,
   input wire logic [COUNT_W-1:0] ch0_count,
   input wire logic               irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence last_byte0;
      byte_done && chan_grant == 2'b01 && ch0_count == 16'h1;
   endsequence
   sequence nmi_held;
      $rose(nmi_pulse) && !io_wr ##1 (nmi_pulse && !io_wr)[*3];
   endsequence
   grant_prio_a: assert property (chan_req[0] && chan_active[0] |-> chan_grant == 2'b01) else $error("grant order");
   grant_gate_a: assert property (chan_grant[1] |-> chan_active[1] && chan_req[1] && !chan_grant[0]) else $error("grant gate");
   count_dec_a: assert property (byte_done && chan_grant == 2'b01 |=> ch0_count == $past(ch0_count) - 16'h1) else $error("count step");
   end_clear_a: assert property (last_byte0 |=> !chan_active[0]) else $error("end enable");
   nmi_stop_a: assert property (nmi_held |=> chan_active == 2'b00) else $error("nmi stop");
   enable_set_a: assert property (io_wr && io_addr == 8'h30 && io_wdata[7] && !io_wdata[5] && !byte_done |=> chan_active[1]) else $error("enable set");
   guard_hold_a: assert property (io_wr && io_addr == 8'h30 && io_wdata[5] && !byte_done && !nmi_pulse |=> $stable(chan_active[1])) else $error("guard");
   guard_read_a: assert property (io_rd && io_addr == 8'h30 |=> io_rdata[5:4] == 2'b11 && !io_rdata[1]) else $error("guard read");
   miss_read_a: assert property (io_rd && !io_hit |=> io_rdata == 8'h00) else $error("unmapped read");
   irq_on_a: assert property (io_wr && io_addr == 8'h30 && io_wdata[2] && !io_wdata[4] && !io_wdata[6] |=> irq) else $error("irq request");
endmodule
bind tcs_transfer_controller tcs_transfer_controller_asserts #(.COUNT_W(COUNT_W)) i_chk (.clk, .sys_rst, .io_addr,
   .io_wdata, .io_wr, .io_rd, .io_rdata, .io_hit, .nmi_pulse, .chan_req, .chan_grant, .byte_done, .chan_active,
   .ch0_count, .irq);
`default_nettype wire

// *** tb/tcs_transfer_controller_tb_top.sv ***
// self-checking bench for the transfer controller registers
`timescale 1ns/1ps
`default_nettype none
module tcs_transfer_controller_tb_top;
   logic clk = 0, sys_rst = 1, io_wr = 0, io_rd = 0, nmi_pulse = 0, byte_done, io_hit, irq;
   logic [7:0] io_addr = 0, io_wdata = 0, io_rdata;
   logic [1:0] want = 0, chan_req, chan_grant, chan_active;
   logic [3:0] lag = 0;
   logic [15:0] ch0_count, ch1_count, ch1_io_addr;
   logic [19:0] ch1_mem_addr;
   int miscompares = 0, samples_checked = 0;
   always #4 clk = ~clk;
   tcs_transfer_controller i_tcs_transfer_controller (.clk, .sys_rst, .io_addr, .io_wdata, .io_wr, .io_rd,
      .io_rdata, .io_hit, .nmi_pulse, .chan_req, .chan_grant, .byte_done, .ch1_mem_step(byte_done & chan_grant[1]),
      .ch1_mem_down(1'b1), .chan_active, .ch0_count, .ch1_count, .ch1_mem_addr, .ch1_io_addr, .irq);
   tcs_partner i_tcs_partner (.clk, .want, .lag, .chan_grant, .chan_req, .byte_done);
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
      @(posedge clk) #1 io_wr = 0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) #1 {io_addr, io_rd} = {a, 1'b1};
      @(posedge clk) #1 io_rd = 0;
      chk(io_rdata, exp);
   endtask
   task idle(input logic [1:0] m);
      for (int i = 0; i < 80 && (chan_active & m) != 0; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task t_reset_map;
      rd(8'h30, 8'h30);
      rd(8'h2D, 8'h00);
      wr(8'h28, 8'h11);
      wr(8'h29, 8'h22);
      wr(8'h2A, 8'h03);
      wr(8'h2B, 8'h33);
      wr(8'h2C, 8'h44);
      chk(ch1_mem_addr, 20'h32211);
      chk(ch1_io_addr, 16'h4433);
      rd(8'h29, 8'h22);
   endtask
   task t_ch0_end;
      wr(8'h26, 8'h02);
      wr(8'h27, 8'h00);
      wr(8'h30, 8'h64);
      chk(chan_active, 2'b01);
      chk(irq, 1'b0);
      rd(8'h30, 8'h75);
      want = 2'b01;
      idle(2'b01);
      chk(ch0_count, 16'h0000);
      chk(irq, 1'b1);
      rd(8'h30, 8'h35);
      want = 2'b00;
   endtask
   task t_guard;
      wr(8'h30, 8'h40);
      chk(chan_active, 2'b01);
      wr(8'h30, 8'h04);
      chk(chan_active, 2'b00);
      chk(irq, 1'b1);
      wr(8'h30, 8'hF0);
      chk(chan_active, 2'b00);
      chk(irq, 1'b0);
      rd(8'h30, 8'h31);
   endtask
   task t_nmi_resume;
      wr(8'h2E, 8'h03);
      wr(8'h2F, 8'h00);
      wr(8'h30, 8'h90);
      chk(chan_active, 2'b10);
      @(posedge clk) #1 nmi_pulse = 1;
      repeat (4) @(posedge clk);
      #1 nmi_pulse = 0;
      chk(chan_active, 2'b00);
      rd(8'h30, 8'hB0);
      wr(8'h30, 8'hB1);
      chk(chan_active, 2'b00);
      want = 2'b10;
      lag = 4'h3;
      wr(8'h30, 8'h90);
      chk(chan_active, 2'b10);
      idle(2'b10);
      chk(ch1_count, 16'h0000);
      chk(ch1_mem_addr, 20'h3220E);
      chk(ch1_io_addr, 16'h4433);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 sys_rst = 0;
      t_reset_map;
      t_ch0_end;
      t_guard;
      t_nmi_resume;
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
endmodule
`default_nettype wire
